/* hdl/feature_cfg_params.svh */
`ifndef FEATURE_CFG_PARAMS_SVH
`define FEATURE_CFG_PARAMS_SVH
// -----------------------------------------------------------------
// Feature identifiers
// -----------------------------------------------------------------
`define FID_KEEPALIVE     8'h0F
`define FID_THERMAL       8'h10
// -----------------------------------------------------------------
// Completion status codes
// -----------------------------------------------------------------
`define STS_SUCCESS       8'h00
`define STS_INVALID_FIELD 8'h02
// -----------------------------------------------------------------
// Field layout of the thermal dword
// -----------------------------------------------------------------
`define LIGHT_MSB         31
`define LIGHT_LSB         16
`define HEAVY_MSB         15
`define HEAVY_LSB         0
// -----------------------------------------------------------------
// Reset and default values
// -----------------------------------------------------------------
`define KA_DEFAULT_MS     32'h0001_D4C0
`define KA_DISABLED       32'h0000_0000
`define TEMP_OFF          16'h0000
`define TS_ORIGIN_RESET   3'h0
`define TS_ORIGIN_HOST    3'h1
// -----------------------------------------------------------------
// Timing counts
// -----------------------------------------------------------------
`define DIV_LAST          6'h1F
`define SYNC_WAIT         2'h2
`define KA_SET_LATENCY    34
`endif

/* hdl/feature_cfg_pkg.sv */
package feature_cfg_pkg;
   typedef logic [31:0] dword_t;
   typedef logic [15:0] temp_t;
   typedef logic [7:0]  byte_t;
   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_DIV, ST_CPL} fsm_e;
endpackage

/* hdl/keepalive_thermal_feature_cfg.sv */
`timescale 1ns/1ps
`include "feature_cfg_params.svh"

module keepalive_thermal_feature_cfg (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   cmd_valid,
   input  wire logic                   cmd_is_set,
   input  wire feature_cfg_pkg::byte_t cmd_fid,
   input  wire feature_cfg_pkg::dword_t cmd_dw11,
   input  wire feature_cfg_pkg::temp_t keepalive_granularity,
   input  wire feature_cfg_pkg::temp_t min_mgmt_temp,
   input  wire feature_cfg_pkg::temp_t max_mgmt_temp,
   input  wire logic                   fabric_needs_keepalive,
   input  wire logic                   ts_host_load,
   input  wire logic                   ts_count_paused,
   output logic                        cmd_ready,
   output logic                        cpl_valid,
   output feature_cfg_pkg::byte_t      cpl_status,
   output feature_cfg_pkg::dword_t     cpl_dw0,
   output feature_cfg_pkg::dword_t     keepalive_timeout_ms,
   output logic                        keepalive_enabled,
   output feature_cfg_pkg::temp_t      light_throttle_temp,
   output feature_cfg_pkg::temp_t      heavy_throttle_temp,
   output logic                        light_throttle_en,
   output logic                        heavy_throttle_en,
   output logic [2:0]                  ts_origin,
   output logic                        ts_gap
);
   import feature_cfg_pkg::*;

   // -----------------------------------------------------------------
   // Strap synchroniser
   // -----------------------------------------------------------------
   logic fab_meta;
   logic fab_sync;

   // Two flops before the strap is used
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fab_meta <= 1'b0;
         fab_sync <= 1'b0;
      end else begin
         fab_meta <= fabric_needs_keepalive;
         fab_sync <= fab_meta;
      end
   end

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   fsm_e        state;
   logic [1:0]  init_cnt;
   logic [5:0]  div_cnt;
   logic [16:0] rem;
   dword_t      dvd;
   dword_t      ka_req;
   logic        is_init;
   temp_t       g_eff;
   temp_t       req_light;
   temp_t       req_heavy;
   logic        take;
   logic        bad_range;
   logic        bad_order;

   // Request fields and checks
   assign take      = cmd_valid && cmd_ready;
   assign g_eff     = (keepalive_granularity == `TEMP_OFF) ? 16'h0001 : keepalive_granularity;
   assign req_light = cmd_dw11[`LIGHT_MSB:`LIGHT_LSB];
   assign req_heavy = cmd_dw11[`HEAVY_MSB:`HEAVY_LSB];
   assign bad_range = ((req_light != `TEMP_OFF)
                       && (req_light < min_mgmt_temp || req_light > max_mgmt_temp))
                    || ((req_heavy != `TEMP_OFF)
                       && (req_heavy < min_mgmt_temp || req_heavy > max_mgmt_temp));
   assign bad_order = (req_heavy != `TEMP_OFF) && (req_light >= req_heavy);
   assign cmd_ready = (state == ST_IDLE);

   // Enables derived from stored values
   assign keepalive_enabled = (keepalive_timeout_ms != `KA_DISABLED);
   assign light_throttle_en = (light_throttle_temp != `TEMP_OFF);
   assign heavy_throttle_en = (heavy_throttle_temp != `TEMP_OFF);

   // -----------------------------------------------------------------
   // Controller state and feature storage
   // -----------------------------------------------------------------
   fsm_e        next_state;
   logic [1:0]  next_init_cnt;
   logic [5:0]  next_div_cnt;
   logic [16:0] next_rem;
   dword_t      next_dvd;
   dword_t      next_ka_req;
   logic        next_is_init;
   logic        next_cpl_valid;
   byte_t       next_cpl_status;
   dword_t      next_cpl_dw0;
   dword_t      next_ka;
   temp_t       next_light;
   temp_t       next_heavy;
   logic [16:0] rem_sh;
   logic [32:0] up_sum;
   dword_t      rounded;

   // Next values of the command engine
   always_comb begin
      next_state      = state;
      next_init_cnt   = init_cnt;
      next_div_cnt    = div_cnt;
      next_rem        = rem;
      next_dvd        = dvd;
      next_ka_req     = ka_req;
      next_is_init    = is_init;
      next_cpl_valid  = 1'b0;
      next_cpl_status = cpl_status;
      next_cpl_dw0    = cpl_dw0;
      next_ka         = keepalive_timeout_ms;
      next_light      = light_throttle_temp;
      next_heavy      = heavy_throttle_temp;
      rem_sh          = {rem[15:0], dvd[31]};
      up_sum          = {1'b0, ka_req} + {17'h0_0000, g_eff - rem[15:0]};
      rounded         = ka_req;
      case (state)
         ST_INIT: begin
            // Wait for the strap to settle, then pick the default
            if (init_cnt == `SYNC_WAIT) begin
               if (fab_sync) begin
                  next_ka_req  = `KA_DEFAULT_MS;
                  next_dvd     = `KA_DEFAULT_MS;
                  next_rem     = 17'h0_0000;
                  next_div_cnt = 6'h00;
                  next_is_init = 1'b1;
                  next_state   = ST_DIV;
               end else begin
                  next_ka    = `KA_DISABLED;
                  next_state = ST_IDLE;
               end
            end else begin
               next_init_cnt = init_cnt + 2'h1;
            end
         end
         ST_IDLE: begin
            if (take) begin
               next_cpl_status = `STS_SUCCESS;
               if (cmd_fid == `FID_KEEPALIVE) begin
                  if (cmd_is_set) begin
                     next_ka_req  = cmd_dw11;
                     next_dvd     = cmd_dw11;
                     next_rem     = 17'h0_0000;
                     next_div_cnt = 6'h00;
                     next_is_init = 1'b0;
                     next_state   = ST_DIV;
                  end else begin
                     next_cpl_valid = 1'b1;
                     next_cpl_dw0   = keepalive_timeout_ms;
                  end
               end else if (cmd_fid == `FID_THERMAL) begin
                  next_cpl_valid = 1'b1;
                  if (!cmd_is_set) begin
                     next_cpl_dw0 = {light_throttle_temp, heavy_throttle_temp};
                  end else if (bad_range || bad_order) begin
                     next_cpl_status = `STS_INVALID_FIELD;
                  end else begin
                     next_light = req_light;
                     next_heavy = req_heavy;
                  end
               end else begin
                  next_cpl_valid  = 1'b1;
                  next_cpl_status = `STS_INVALID_FIELD;
               end
            end
         end
         ST_DIV: begin
            // One restoring division step per cycle, remainder only
            next_rem = (rem_sh >= {1'b0, g_eff}) ? rem_sh - {1'b0, g_eff} : rem_sh;
            next_dvd = {dvd[30:0], 1'b0};
            next_div_cnt = div_cnt + 6'h01;
            if (div_cnt == `DIV_LAST) begin
               next_state = ST_CPL;
            end
         end
         ST_CPL: begin
            // Round up; saturate to the lower multiple on overflow
            if (rem != 17'h0_0000) begin
               rounded = up_sum[32] ? ka_req - {16'h0000, rem[15:0]} : up_sum[31:0];
            end
            next_ka    = rounded;
            next_state = ST_IDLE;
            if (!is_init) begin
               next_cpl_valid  = 1'b1;
               next_cpl_status = `STS_SUCCESS;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Register the command engine
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state                <= ST_INIT;
         init_cnt             <= 2'h0;
         div_cnt              <= 6'h00;
         rem                  <= 17'h0_0000;
         dvd                  <= `KA_DISABLED;
         ka_req               <= `KA_DISABLED;
         is_init              <= 1'b0;
         cpl_valid            <= 1'b0;
         cpl_status           <= `STS_SUCCESS;
         cpl_dw0              <= `KA_DISABLED;
         keepalive_timeout_ms <= `KA_DISABLED;
         light_throttle_temp  <= `TEMP_OFF;
         heavy_throttle_temp  <= `TEMP_OFF;
      end else begin
         state                <= next_state;
         init_cnt             <= next_init_cnt;
         div_cnt              <= next_div_cnt;
         rem                  <= next_rem;
         dvd                  <= next_dvd;
         ka_req               <= next_ka_req;
         is_init              <= next_is_init;
         cpl_valid            <= next_cpl_valid;
         cpl_status           <= next_cpl_status;
         cpl_dw0              <= next_cpl_dw0;
         keepalive_timeout_ms <= next_ka;
         light_throttle_temp  <= next_light;
         heavy_throttle_temp  <= next_heavy;
      end
   end

   // -----------------------------------------------------------------
   // Timestamp origin and gap flag
   // -----------------------------------------------------------------
   logic [2:0] next_ts_origin;
   logic       next_ts_gap;

   // Pause event wins over a host load's gap clear in the same cycle; the origin still loads
   always_comb begin
      next_ts_origin = ts_origin;
      next_ts_gap    = ts_gap;
      if (ts_host_load) begin
         next_ts_origin = `TS_ORIGIN_HOST;
         next_ts_gap    = 1'b0;
      end
      if (ts_count_paused) begin
         next_ts_gap = 1'b1;
      end
   end

   // Register the timestamp flags
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ts_origin <= `TS_ORIGIN_RESET;
         ts_gap    <= 1'b0;
      end else begin
         ts_origin <= next_ts_origin;
         ts_gap    <= next_ts_gap;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   localparam int KA_LAT = `KA_SET_LATENCY;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_get_keepalive_dw0: assert property (
      take && !cmd_is_set && cmd_fid == `FID_KEEPALIVE
      |=> cpl_valid && cpl_dw0 == $past(keepalive_timeout_ms))
      else $error("keep-alive get returned wrong dword");

   a_get_thermal_dw0: assert property (
      take && !cmd_is_set && cmd_fid == `FID_THERMAL
      |=> cpl_valid && cpl_dw0 == {$past(light_throttle_temp), $past(heavy_throttle_temp)})
      else $error("thermal get returned wrong dword");

   a_ka_set_done: assert property (
      take && cmd_is_set && cmd_fid == `FID_KEEPALIVE
      |-> ##KA_LAT cpl_valid && cpl_status == `STS_SUCCESS
          && ((keepalive_timeout_ms - $past(cmd_dw11, KA_LAT) < {16'h0000, g_eff})
              || ($past(cmd_dw11, KA_LAT) - keepalive_timeout_ms < {16'h0000, g_eff})))
      else $error("keep-alive set did not complete on time");

   a_ka_round_up: assert property (
      take && cmd_is_set && cmd_fid == `FID_KEEPALIVE
      |-> ##KA_LAT (keepalive_timeout_ms % {16'h0000, g_eff}) == 32'h0000_0000)
      else $error("keep-alive timeout not a granularity multiple");

   a_ka_zero_off: assert property (
      take && cmd_is_set && cmd_fid == `FID_KEEPALIVE && cmd_dw11 == `KA_DISABLED
      |-> ##KA_LAT !keepalive_enabled)
      else $error("zero keep-alive timeout left timer enabled");

   a_range_reject: assert property (
      take && cmd_is_set && cmd_fid == `FID_THERMAL && bad_range
      |=> cpl_status == `STS_INVALID_FIELD && $stable(light_throttle_temp) && $stable(heavy_throttle_temp))
      else $error("out of range threshold accepted");

   a_order_reject: assert property (
      take && cmd_is_set && cmd_fid == `FID_THERMAL && req_heavy != `TEMP_OFF && req_light >= req_heavy
      |=> cpl_valid && cpl_status == `STS_INVALID_FIELD && $stable(heavy_throttle_temp))
      else $error("misordered thresholds accepted");

   a_thermal_store: assert property (
      take && cmd_is_set && cmd_fid == `FID_THERMAL && !bad_range && !bad_order
      |=> cpl_status == `STS_SUCCESS && light_throttle_temp == $past(req_light)
          && heavy_throttle_temp == $past(req_heavy))
      else $error("valid thresholds not stored");

   a_ts_host_origin: assert property (
      ts_host_load && !ts_count_paused |=> ts_origin == `TS_ORIGIN_HOST && !ts_gap)
      else $error("host load did not set origin");

   a_ts_gap_set: assert property (
      ts_count_paused |=> ts_gap ##1 (ts_gap || $past(ts_host_load)))
      else $error("pause did not raise gap flag");

endmodule

/* tb/host_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Host side: issues set and get commands
// ----------------------------------------
module host_model (
   input  wire logic                    sys_clk,
   input  wire logic                    cmd_ready,
   input  wire logic                    cpl_valid,
   input  wire feature_cfg_pkg::byte_t  cpl_status,
   input  wire feature_cfg_pkg::dword_t cpl_dw0,
   output logic                         cmd_valid,
   output logic                         cmd_is_set,
   output feature_cfg_pkg::byte_t       cmd_fid,
   output feature_cfg_pkg::dword_t      cmd_dw11
);
   import feature_cfg_pkg::*;

   // Idle request lines at time zero
   initial begin
      cmd_valid  = 1'b0;
      cmd_is_set = 1'b0;
      cmd_fid    = 8'h00;
      cmd_dw11   = 32'h0000_0000;
   end

   // One command: hold until taken, then wait for its completion
   task automatic issue(input logic set, input byte_t fid, input dword_t dw,
                        output byte_t sts, output dword_t d0, output logic ok);
      ok = 1'b0;
      @(posedge sys_clk);
      cmd_valid  <= 1'b1;
      cmd_is_set <= set;
      cmd_fid    <= fid;
      cmd_dw11   <= dw;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge sys_clk);
         ok = (cmd_ready === 1'b1);
      end
      cmd_valid <= 1'b0;
      cmd_fid   <= ~fid; // Released fid and dword lines do not keep the last value; cmd_is_set does
      cmd_dw11  <= ~dw;
      ok = 1'b0;
      for (int n = 0; n < 100 && !ok; n++) begin
         @(posedge sys_clk);
         ok  = (cpl_valid === 1'b1);
         sts = cpl_status;
         d0  = cpl_dw0;
      end
   endtask
endmodule

/* tb/tb_keepalive_thermal_feature_cfg.sv */
`timescale 1ns/1ps
`include "feature_cfg_params.svh"

module tb_keepalive_thermal_feature_cfg;
   import feature_cfg_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic   sys_clk, rst, cmd_valid, cmd_is_set, fabric_needs_keepalive, ts_host_load, ts_count_paused;
   logic   cmd_ready, cpl_valid, keepalive_enabled, light_throttle_en, heavy_throttle_en, ts_gap;
   byte_t  cmd_fid, cpl_status;
   dword_t cmd_dw11, cpl_dw0, keepalive_timeout_ms, last_d0;
   temp_t  light_throttle_temp, heavy_throttle_temp;
   logic [2:0] ts_origin;
   int     failures, total_checks;
   dword_t bad_sets [4] = '{32'h00FA_015E, 32'h012C_0190, 32'h015E_015E, 32'h012C_0122};

   // ----------------------------------------
   // Clock, design and host
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   keepalive_thermal_feature_cfg i_keepalive_thermal_feature_cfg (
      .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_is_set(cmd_is_set), .cmd_fid(cmd_fid),
      .cmd_dw11(cmd_dw11), .keepalive_granularity(16'h0007), .min_mgmt_temp(16'h0111),
      .max_mgmt_temp(16'h0175), .fabric_needs_keepalive(fabric_needs_keepalive),
      .ts_host_load(ts_host_load), .ts_count_paused(ts_count_paused), .cmd_ready(cmd_ready),
      .cpl_valid(cpl_valid), .cpl_status(cpl_status), .cpl_dw0(cpl_dw0),
      .keepalive_timeout_ms(keepalive_timeout_ms), .keepalive_enabled(keepalive_enabled),
      .light_throttle_temp(light_throttle_temp), .heavy_throttle_temp(heavy_throttle_temp),
      .light_throttle_en(light_throttle_en), .heavy_throttle_en(heavy_throttle_en),
      .ts_origin(ts_origin), .ts_gap(ts_gap));

   host_model i_host_model (
      .sys_clk(sys_clk), .cmd_ready(cmd_ready), .cpl_valid(cpl_valid), .cpl_status(cpl_status),
      .cpl_dw0(cpl_dw0), .cmd_valid(cmd_valid), .cmd_is_set(cmd_is_set), .cmd_fid(cmd_fid),
      .cmd_dw11(cmd_dw11));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Command with status check; get data lands in last_d0
   task automatic cmd(input logic set, input byte_t fid, input dword_t dw, input byte_t exp_sts);
      byte_t sts;
      logic  ok;
      i_host_model.issue(set, fid, dw, sts, last_d0, ok);
      check("completion seen", {31'h0, ok}, 32'h0000_0001);
      check("status", {24'h0, sts}, {24'h0, exp_sts});
   endtask

   task automatic do_reset(input logic strap);
      rst                    <= 1'b1;
      fabric_needs_keepalive <= strap;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic ts_pulse(input logic load, input logic pause);
      @(posedge sys_clk);
      ts_host_load    <= load;
      ts_count_paused <= pause;
      @(posedge sys_clk);
      ts_host_load    <= 1'b0;
      ts_count_paused <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   // ----------------------------------------
   // Watchdog: whole run is well under 2000 cycles
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      close_out();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      fabric_needs_keepalive = 1'b0;
      ts_host_load = 1'b0;
      ts_count_paused = 1'b0;
      failures = 0;
      total_checks = 0;
      do_reset(1'b0);
      check("origin after reset", {29'h0, ts_origin}, 32'h0000_0000);
      check("gap after reset", {31'h0, ts_gap}, 32'h0000_0000);
      cmd(1'b0, `FID_KEEPALIVE, 32'h0000_0000, `STS_SUCCESS);
      check("keepalive default", last_d0, 32'h0000_0000);
      cmd(1'b1, `FID_KEEPALIVE, 32'h0000_03E8, `STS_SUCCESS);
      check("keepalive rounded", keepalive_timeout_ms, 32'h0000_03E9);
      check("keepalive on", {31'h0, keepalive_enabled}, 32'h0000_0001);
      cmd(1'b0, `FID_KEEPALIVE, 32'h0000_0000, `STS_SUCCESS);
      check("keepalive get", last_d0, 32'h0000_03E9);
      cmd(1'b1, `FID_KEEPALIVE, 32'h0000_0000, `STS_SUCCESS);
      check("keepalive off", {31'h0, keepalive_enabled}, 32'h0000_0000);
      cmd(1'b1, `FID_THERMAL, 32'h012C_015E, `STS_SUCCESS);
      check("light temp", {16'h0, light_throttle_temp}, 32'h0000_012C);
      check("heavy temp", {16'h0, heavy_throttle_temp}, 32'h0000_015E);
      // Out of range, light at heavy, heavy below light
      foreach (bad_sets[i]) begin
         cmd(1'b1, `FID_THERMAL, bad_sets[i], `STS_INVALID_FIELD);
         check("kept thresholds", {light_throttle_temp, heavy_throttle_temp}, 32'h012C_015E);
      end
      cmd(1'b1, 8'h11, 32'h0000_0000, `STS_INVALID_FIELD);
      check("kept after bad id", {light_throttle_temp, heavy_throttle_temp}, 32'h012C_015E);
      cmd(1'b0, `FID_THERMAL, 32'h0000_0000, `STS_SUCCESS);
      check("thermal get", last_d0, 32'h012C_015E);
      cmd(1'b1, `FID_THERMAL, 32'h0168_0000, `STS_SUCCESS);
      check("heavy stage off", {30'h0, light_throttle_en, heavy_throttle_en}, 32'h0000_0002);
      cmd(1'b1, `FID_THERMAL, 32'h0000_012C, `STS_SUCCESS);
      check("light stage off", {30'h0, light_throttle_en, heavy_throttle_en}, 32'h0000_0001);
      ts_pulse(1'b1, 1'b0);
      check("origin host load", {29'h0, ts_origin}, 32'h0000_0001);
      check("gap still clear", {31'h0, ts_gap}, 32'h0000_0000);
      ts_pulse(1'b0, 1'b1);
      check("gap after pause", {31'h0, ts_gap}, 32'h0000_0001);
      ts_pulse(1'b1, 1'b0);
      check("gap cleared by load", {31'h0, ts_gap}, 32'h0000_0000);
      ts_pulse(1'b1, 1'b1);
      check("origin load and pause", {29'h0, ts_origin}, 32'h0000_0001);
      check("pause wins over load", {31'h0, ts_gap}, 32'h0000_0001);
      do_reset(1'b1);
      check("origin second reset", {29'h0, ts_origin}, 32'h0000_0000);
      check("gap second reset", {31'h0, ts_gap}, 32'h0000_0000);
      cmd(1'b0, `FID_KEEPALIVE, 32'h0000_0000, `STS_SUCCESS);
      check("fabric default", last_d0, 32'h0001_D4C1);
      close_out();
   end
endmodule
